// File: tb/dual_clock_fifo_tb.sv
// Self-checking testbench for the dual clock FIFO
`timescale 1ns/100ps
module dual_clock_fifo_tb;
  import fifo_pkg::*;
  logic mclk, resetn, output_enable_n, fl_n, wxi_n, rxi_n;
  logic rxo_n, wxo_n;
  logic wclk, rclk, wen_n, ren_n, ld_n;
  logic [17:0] din, data_out;
  logic data_out_oe, empty_flag_n, full_flag_n, almost_empty_flag_n;
  logic almost_full_flag_n, half_full_flag_n;
  int errors = 0;
  int total_checks = 0;
  int chain_pulses = 0;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Single device: any chain pulse is a fault
  always @(negedge mclk) begin
    if (resetn && (!rxo_n || !wxo_n)) chain_pulses <= chain_pulses + 1;
  end

  fifo_port_model m (.mclk(mclk), .wclk(wclk), .rclk(rclk), .write_enable_n(wen_n),
    .read_enable_n(ren_n), .offset_load_select_n(ld_n), .data_in(din));

  dual_clock_fifo dut (.mclk(mclk), .resetn(resetn), .wclk(wclk), .rclk(rclk),
    .write_enable_n(wen_n), .read_enable_n(ren_n), .offset_load_select_n(ld_n),
    .output_enable_n(output_enable_n), .first_load_select_n(fl_n),
    .write_chain_in_n(wxi_n), .read_chain_in_n(rxi_n), .data_in(din),
    .data_out(data_out), .data_out_oe(data_out_oe), .empty_flag_n(empty_flag_n),
    .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .half_full_flag_n(half_full_flag_n),
    .read_chain_out_n(rxo_n), .write_chain_out_n(wxo_n));

  ////////////////////////////////////////////////////////////////
  function automatic logic [17:0] pat(input int i);
    return {i[8:0] ^ 9'h155, i[8:0]};
  endfunction

  // Called mid-cycle or on return from a port task, so edge updates have landed
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic settle;
    repeat (14) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic test_reset_offsets;
    @(negedge mclk);
    chk(empty_flag_n, 0, "empty");
    chk(almost_empty_flag_n, 0, "almost empty");
    chk(full_flag_n, 1, "full");
    chk(almost_full_flag_n, 1, "almost full");
    chk(half_full_flag_n, 1, "half full");
    m.rd(1'b0);
    chk(data_out, 18'h0003f, "empty offset default");
    m.rd(1'b0);
    chk(data_out, 18'h0003f, "full offset default");
    m.wr(18'h3f005, 1'b0);
    m.wr(18'h3f00a, 1'b0);
    m.rd(1'b0);
    chk(data_out, 18'h00005, "empty offset loaded");
    m.rd(1'b0);
    chk(data_out, 18'h0000a, "full offset loaded");
    m.rd(1'b1);
    settle();
    chk(data_out, 18'h0000a, "read while empty");
    chk(empty_flag_n, 0, "offset load stored nothing");
    $display("test reset_offsets done");
  endtask

  task automatic test_almost_empty;
    for (int k = 1; k <= 6; k++) m.wr(pat(k), 1'b1);
    settle();
    chk(almost_empty_flag_n, 1, "six words above offset");
    chk(empty_flag_n, 1, "not empty");
    m.rd(1'b1);
    settle();
    chk(almost_empty_flag_n, 0, "five words at offset");
    chk(data_out, pat(1), "held between reads");
    for (int k = 2; k <= 6; k++) begin
      m.rd(1'b1);
      chk(data_out, pat(k), "popped word");
    end
    m.rd(1'b1);
    settle();
    chk(data_out, pat(6), "pop refused when empty");
    chk(empty_flag_n, 0, "empty again");
    $display("test almost_empty done");
  endtask

  task automatic test_fill;
    for (int k = 1; k <= 512; k++) begin
      m.wr(pat(k), 1'b1);
      @(negedge mclk);
      if (k == 256 || k == 257) chk(half_full_flag_n, k == 256, "half full");
      if (k == 501 || k == 502) chk(almost_full_flag_n, k == 501, "almost full");
      if (k == 511 || k == 512) chk(full_flag_n, k == 511, "full");
    end
    m.wr(18'h2aaaa, 1'b1);
    for (int k = 1; k <= 512; k++) begin
      m.rd(1'b1);
      chk(data_out, pat(k), "drained word");
    end
    settle();
    chk(empty_flag_n, 0, "extra write dropped");
    chk(chain_pulses, 0, "no chain pulse");
    $display("test fill done");
  endtask

  task automatic test_output_enable;
    @(posedge mclk);
    output_enable_n <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(data_out_oe, 0, "bus released");
    @(posedge mclk);
    output_enable_n <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(data_out_oe, 1, "bus driven");
    $display("test output_enable done");
  endtask

  task automatic test_fall_through;
    @(posedge mclk);
    fl_n <= 1'b0;
    wxi_n <= 1'b0;
    rxi_n <= 1'b0;
    do_reset();
    m.wr(pat(7), 1'b1);
    @(negedge mclk);
    chk(data_out, 0, "not yet shown");
    settle();
    settle();
    chk(data_out, pat(7), "first word fell through");
    chk(empty_flag_n, 0, "output ready");
    chk(full_flag_n, 0, "input ready");
    chk(almost_full_flag_n, 1, "async almost full");
    chk(almost_empty_flag_n, 0, "async almost empty");
    $display("test fall_through done");
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    resetn = 1'b0;
    output_enable_n = 1'b0;
    fl_n = 1'b1;
    wxi_n = 1'b1;
    rxi_n = 1'b1;
    do_reset();
    test_reset_offsets();
    test_almost_empty();
    test_fill();
    test_output_enable();
    test_fall_through();
    give_verdict();
  end
endmodule // dual_clock_fifo_tb

// File: tb/fifo_port_model.sv
// Writer and reader pin model for the dual clock FIFO ports
`timescale 1ns/100ps
module fifo_port_model (
  input wire logic mclk,
  output logic wclk,
  output logic rclk,
  output logic write_enable_n,
  output logic read_enable_n,
  output logic offset_load_select_n,
  output logic [17:0] data_in
);
  // Port clocks run free, six mclk a period; read side half a period late
  int wph = 0;
  int rph = 3;
  assign wclk = (wph < 3);
  assign rclk = (rph < 3);
  initial begin
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    offset_load_select_n = 1'b1;
    data_in = 18'h15555;
  end
  always_ff @(posedge mclk) begin
    wph <= (wph + 1) % 6;
    rph <= (rph + 1) % 6;
  end
  ////////////////////////////////////////////////////////////////
  // Set one mclk before one rising port edge, released after it
  task automatic wr(input logic [17:0] d, input logic ld_n);
    do @(posedge mclk); while (wph != 4);
    write_enable_n <= 1'b0;
    offset_load_select_n <= ld_n;
    data_in <= d;
    do @(posedge mclk); while (wph != 4);
    write_enable_n <= 1'b1;
    offset_load_select_n <= 1'b1;
    data_in <= ~d; // Stale bus must not mirror the last word
  endtask
  task automatic rd(input logic ld_n);
    do @(posedge mclk); while (rph != 4);
    read_enable_n <= 1'b0;
    offset_load_select_n <= ld_n;
    do @(posedge mclk); while (rph != 4);
    read_enable_n <= 1'b1;
    offset_load_select_n <= 1'b1;
  endtask
endmodule // fifo_port_model

// File: verilog/dual_clock_fifo.sv
// Dual port FIFO with programmable almost flags, offset load and fall-through mode
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "fifo_defs.svh"

//Function
// R1: Load-select plus write enable loads offsets
// R2: Load-select plus read enable reads offsets out
// R3: Output bus driven only while enable low
// R4: Almost-empty low within empty offset
// R5: Almost-full low within full offset
// R6: Empty offset resets to 63 or 127
// R7: Full offset resets to 63 or 127
// R8: Eighteen-bit words stored unchanged
// R9: Read enable pops one word per edge
// R10: No pop while empty
// R11: Read enable high holds output register
// R12: Reset clears pointers and sets flags
// R13: Controller resets before first write
// R14: Mode chosen from three strap inputs
// R15: Chain inputs wired to previous device
// R16: Pulse read chain out on last read
// R17: Write stores only when not full
// R18: Offset loads alternate empty then full
// R19: Write enable ignored while full
// R20: Fall-through shows first word third edge
// R21: Half-full low above half occupancy
// R22: Pointers cross sides through synchronisers
// R23: Empty flags read side, full write side
module dual_clock_fifo
  import fifo_pkg::*;
#(
  parameter int ADDR_W = `FIFO_DEPTH_SMALL_LOG2,
  parameter bit DEPTH_EXPAND = 1'b0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wclk,
  input wire logic rclk,
  input wire logic write_enable_n,
  input wire logic read_enable_n,
  input wire logic offset_load_select_n,
  input wire logic output_enable_n,
  input wire logic first_load_select_n,
  input wire logic write_chain_in_n,
  input wire logic read_chain_in_n,
  input wire logic [`FIFO_DATA_W-1:0] data_in,
  output logic [`FIFO_DATA_W-1:0] data_out,
  output logic data_out_oe,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic half_full_flag_n,
  output logic read_chain_out_n,
  output logic write_chain_out_n
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int PW = ADDR_W + 1;
  localparam int CW = `FIFO_CMP_W;
  localparam int SW = `FIFO_DATA_W + 9;
  localparam logic [11:0] OFF_DEF =
    (ADDR_W == `FIFO_DEPTH_SMALL_LOG2) ? `FIFO_OFFSET_DEF_SMALL : `FIFO_OFFSET_DEF_LARGE; // [R6] [R7]

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin sampling: clocks, controls and data share one delay so they stay aligned
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic wclk_s, rclk_s, wen_s, ren_s, ld_s, oe_s, fl_s, wxi_s, rxi_s;
  logic [`FIFO_DATA_W-1:0] din_s;
  logic wclk_d_reg, rclk_d_reg;
  logic wr_edge, rd_edge;

  assign pins_raw = {wclk, rclk, write_enable_n, read_enable_n, offset_load_select_n,
                     output_enable_n, first_load_select_n, write_chain_in_n, read_chain_in_n, data_in};

  pin_sync #(.W(SW)) u_pin_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {wclk_s, rclk_s, wen_s, ren_s, ld_s, oe_s, fl_s, wxi_s, rxi_s, din_s} = pins_s;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
    end else begin
      wclk_d_reg <= wclk_s;
      rclk_d_reg <= rclk_s;
    end
  end

  assign wr_edge = wclk_s & ~wclk_d_reg;
  assign rd_edge = rclk_s & ~rclk_d_reg;

  //////////////////////////////////////////////////////////////////////////
  // Mode straps, caught once after reset release
  fifo_mode_t mode_reg;
  logic [1:0] mode_wait_reg;

  // Straps read on the third edge: before that the synchroniser still shows its reset zeros
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= '0;
      mode_wait_reg <= 2'h0;
    end else if (mode_wait_reg != 2'h3) begin
      mode_wait_reg <= mode_wait_reg + 2'h1;
      if (mode_wait_reg == 2'h2) begin
        mode_reg.depth_expand <= DEPTH_EXPAND;
        mode_reg.fall_through <= !DEPTH_EXPAND && !fl_s && !wxi_s; // [R14]
        mode_reg.async_flags <= !DEPTH_EXPAND && !rxi_s; // [R14]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage and offset registers
  logic [`FIFO_DATA_W-1:0] mem [DEPTH];
  offset_pair_t offsets_reg;
  offset_sel_t wsel_reg, rsel_reg;
  logic [PW-1:0] wbin_reg, rbin_reg, wgray_reg, rgray_reg;
  logic [PW-1:0] wgray_rs, rgray_ws, wbin_rs, rbin_ws;
  logic offset_wr, fifo_wr;

  // Gray pointers so a half-changed value is off by at most one, never falsely roomy
  pin_sync #(.W(PW)) u_wptr_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(wgray_reg),
    .q(wgray_rs)
  ); // [R22]

  pin_sync #(.W(PW)) u_rptr_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(rgray_reg),
    .q(rgray_ws)
  ); // [R22]

  assign wbin_rs = gray2bin(wgray_rs);
  assign rbin_ws = gray2bin(rgray_ws);
  assign offset_wr = wr_edge && !ld_s && !wen_s; // [R1]
  assign fifo_wr = wr_edge && ld_s && !wen_s && full_flag_int(wbin_reg, rbin_ws) == 1'b0; // [R17] [R19]

  function automatic logic full_flag_int(input logic [PW-1:0] w, input logic [PW-1:0] r);
    return (PW'(w - r) == PW'(DEPTH));
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      offsets_reg <= '{empty_off: OFF_DEF, full_off: OFF_DEF}; // [R6] [R7]
      wsel_reg <= SEL_EMPTY_OFFSET;
    end else if (offset_wr) begin
      unique case (wsel_reg)
        SEL_EMPTY_OFFSET: begin
          offsets_reg.empty_off <= din_s[`FIFO_OFFSET_W-1:0]; // [R1]
          wsel_reg <= SEL_FULL_OFFSET; // [R18]
        end
        SEL_FULL_OFFSET: begin
          offsets_reg.full_off <= din_s[`FIFO_OFFSET_W-1:0]; // [R1]
          wsel_reg <= SEL_EMPTY_OFFSET; // [R18]
        end
      endcase
    end
  end

  // Memory has no reset: contents are meaningless until written
  always_ff @(posedge mclk) begin
    if (fifo_wr) begin
      mem[wbin_reg[ADDR_W-1:0]] <= din_s; // [R8]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write side pointer and flags
  logic [PW-1:0] wbin_next;
  logic [PW-1:0] wcount_next;
  logic [CW-1:0] wfree_next;

  assign wbin_next = fifo_wr ? PW'(wbin_reg + 1'b1) : wbin_reg;
  assign wcount_next = PW'(wbin_next - rbin_ws);
  assign wfree_next = CW'(CW'(DEPTH) - CW'(wcount_next));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wbin_reg <= '0; // [R12]
      wgray_reg <= '0;
    end else if (fifo_wr) begin
      wbin_reg <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
    end
  end

  logic full_now;
  assign full_now = (CW'(wcount_next) == CW'(DEPTH));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      full_flag_n <= 1'b1; // [R12]
      almost_full_flag_n <= 1'b1; // [R12]
      half_full_flag_n <= 1'b1;
      write_chain_out_n <= 1'b1;
    end else begin
      write_chain_out_n <= !(mode_reg.depth_expand && fifo_wr && &wbin_reg[ADDR_W-1:0]);
      if (wr_edge) begin
        // Fall-through shows input-ready: high means no room
        full_flag_n <= mode_reg.fall_through ? full_now : !full_now; // [R23]
        half_full_flag_n <= !(CW'(wcount_next) > CW'(DEPTH / 2)); // [R21]
      end
      if (wr_edge || mode_reg.async_flags) begin
        almost_full_flag_n <= !(wfree_next <= CW'(offsets_reg.full_off)); // [R5] [R23]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read side: output register, pointer and flags
  logic [PW-1:0] rcount;
  logic rd_offset, pop, out_valid_reg, out_valid_next;
  logic [1:0] fw_cnt_reg;
  logic [PW-1:0] rbin_next, rcount_next;

  assign rcount = PW'(wbin_rs - rbin_reg);
  assign rd_offset = rd_edge && !ld_s && !ren_s; // [R2]

  always_comb begin
    pop = 1'b0;
    out_valid_next = out_valid_reg;
    if (rd_edge && !rd_offset && rcount != '0) begin // [R10]
      if (!mode_reg.fall_through) begin
        pop = !ren_s; // [R9]
      end else if (!out_valid_reg) begin
        pop = (fw_cnt_reg == `FIFO_FALL_THROUGH_MODE_LOAD_EDGE); // [R20]
      end else begin
        pop = !ren_s; // [R9]
      end
    end
    if (pop) begin
      out_valid_next = 1'b1;
    end else if (rd_edge && !rd_offset && out_valid_reg && !ren_s && mode_reg.fall_through) begin
      out_valid_next = 1'b0;
    end
  end

  assign rbin_next = pop ? PW'(rbin_reg + 1'b1) : rbin_reg;
  assign rcount_next = PW'(wbin_rs - rbin_next);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fw_cnt_reg <= 2'h0;
    end else if (!mode_reg.fall_through || out_valid_reg || rcount == '0) begin
      fw_cnt_reg <= 2'h0;
    end else if (rd_edge && !rd_offset && !pop) begin
      fw_cnt_reg <= fw_cnt_reg + 2'h1;
    end else if (pop) begin
      fw_cnt_reg <= 2'h0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rbin_reg <= '0; // [R12]
      rgray_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= out_valid_next;
      if (pop) begin
        rbin_reg <= rbin_next;
        rgray_reg <= rbin_next ^ (rbin_next >> 1);
      end
    end
  end

  // Output register holds whenever nothing is popped or read back
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_out <= '0;
      rsel_reg <= SEL_EMPTY_OFFSET;
    end else if (rd_offset) begin
      unique case (rsel_reg)
        SEL_EMPTY_OFFSET: begin
          data_out <= {{(`FIFO_DATA_W - `FIFO_OFFSET_W){1'b0}}, offsets_reg.empty_off}; // [R2]
          rsel_reg <= SEL_FULL_OFFSET; // [R18]
        end
        SEL_FULL_OFFSET: begin
          data_out <= {{(`FIFO_DATA_W - `FIFO_OFFSET_W){1'b0}}, offsets_reg.full_off}; // [R2]
          rsel_reg <= SEL_EMPTY_OFFSET; // [R18]
        end
      endcase
    end else if (pop) begin
      data_out <= mem[rbin_reg[ADDR_W-1:0]]; // [R8] [R9] [R11]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      empty_flag_n <= 1'b0; // [R12]
      almost_empty_flag_n <= 1'b0; // [R12]
      read_chain_out_n <= 1'b1;
      data_out_oe <= 1'b0;
    end else begin
      data_out_oe <= !oe_s; // [R3]
      read_chain_out_n <= !(mode_reg.depth_expand && pop && &rbin_reg[ADDR_W-1:0]); // [R16]
      if (rd_edge) begin
        // Fall-through shows output-ready: low means a word waits on the outputs
        empty_flag_n <= mode_reg.fall_through ? !out_valid_next : (rcount_next != '0); // [R23]
      end
      if (rd_edge || mode_reg.async_flags) begin
        almost_empty_flag_n <= !(CW'(rcount_next) <= CW'(offsets_reg.empty_off)); // [R4] [R23]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_offset_load_empty;
    offset_wr && wsel_reg == SEL_EMPTY_OFFSET;
  endsequence

  sequence s_offset_load_full;
    offset_wr && wsel_reg == SEL_FULL_OFFSET;
  endsequence

  a_offset_load_order: assert property (s_offset_load_empty |=> wsel_reg == SEL_FULL_OFFSET && // [R18]
      offsets_reg.empty_off == $past(din_s[11:0]))
    else $error("empty offset not loaded first");

  a_offset_load_wrap: assert property (s_offset_load_full |=> wsel_reg == SEL_EMPTY_OFFSET && // [R1]
      offsets_reg.full_off == $past(din_s[11:0]))
    else $error("full offset load did not wrap");

  a_full_blocks_write: assert property (wr_edge && PW'(wbin_reg - rbin_ws) == PW'(DEPTH) |=> // [R17]
      $stable(wbin_reg))
    else $error("write pointer moved while full");

  a_empty_blocks_read: assert property (rd_edge && rcount == '0 |=> $stable(rbin_reg)) // [R10]
    else $error("read pointer moved while empty");

  a_hold_output: assert property (rd_edge && ren_s && !mode_reg.fall_through |=> $stable(data_out)) // [R11]
    else $error("output register changed without read");

  a_pop_advance: assert property (rd_edge && !ren_s && ld_s && rcount != '0 && // [R9]
      !mode_reg.fall_through |=> rbin_reg == PW'($past(rbin_reg) + 1'b1))
    else $error("read did not advance pointer");

  a_oe_drive: assert property (!oe_s |=> data_out_oe) // [R3]
    else $error("output bus not driven");

  a_oe_release: assert property (oe_s |=> !data_out_oe) // [R3]
    else $error("output bus not released");

  a_half_full_level: assert property (wr_edge |=> half_full_flag_n == // [R21]
      !(PW'(wbin_reg - $past(rbin_ws)) > PW'(DEPTH / 2)))
    else $error("half full flag wrong");
endmodule // dual_clock_fifo

// File: verilog/fifo_defs.svh
// Constants for the dual clock FIFO: widths, offsets, reset values, timing counts
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH
`define FIFO_DATA_W 18
`define FIFO_OFFSET_W 12
`define FIFO_DEPTH_SMALL_LOG2 9
`define FIFO_OFFSET_DEF_SMALL 12'h03f
`define FIFO_OFFSET_DEF_LARGE 12'h07f
`define FIFO_FALL_THROUGH_MODE_LOAD_EDGE 2'h2
`define FIFO_CMP_W 13
`endif

// File: verilog/fifo_pkg.sv
// Types shared by the dual clock FIFO
package fifo_pkg;
  typedef enum logic {
    SEL_EMPTY_OFFSET = 1'b0,
    SEL_FULL_OFFSET = 1'b1
  } offset_sel_t;

  typedef struct packed {
    logic [11:0] empty_off;
    logic [11:0] full_off;
  } offset_pair_t;

  typedef struct packed {
    logic fall_through;
    logic async_flags;
    logic depth_expand;
  } fifo_mode_t;
endpackage

// File: verilog/pin_sync.sv
// Two flip-flop synchroniser for pins arriving from outside the mclk domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // pin_sync
